// ---- csg_pkg.sv ----
/*
 * Package of the strap, identification and general purpose I/O register bank:
 * register offsets, strap field positions, reset values and the access carrier.
 * Assumes byte-wide register accesses with 12-bit byte addresses from both sides.
 */
`default_nettype none

package csg_pkg;

    // Register byte offsets
    localparam logic [11:0] OFS_POWER_ON_STRAP_CONFIG = 12'hE00;
    localparam logic [11:0] OFS_PRODUCT_IDENTIFIER = 12'hE00;
    localparam logic [11:0] OFS_VENDOR_IDENTIFIER = 12'hE08;
    localparam logic [11:0] OFS_DIGITAL_OUTPUT_DATA = 12'hF00;
    localparam logic [11:0] OFS_GENERAL_PURPOSE_OUTPUTS = 12'hF10;
    localparam logic [11:0] OFS_GENERAL_PURPOSE_INPUTS = 12'hF18;

    // Strap word field positions
    localparam int POS_PORT_COUNT = 0;
    localparam int POS_PORT_PHY_TYPE = 2;
    localparam int POS_CPU_CLOCK_SEL = 6;
    localparam int POS_TX_PHASE_SHIFT = 8;
    localparam int POS_REF_CLOCK_OUT_ENABLE = 10;
    localparam int POS_TRANSPARENT_MII = 11;
    localparam int POS_CTRL_STATUS_MOVE = 12;
    localparam int POS_PHY_ADDR_BIAS = 13;
    localparam int POS_LINK_POLARITY_SELECT = 14;

    // Port count codes
    localparam logic [1:0] PORTS_01 = 2'h0;
    localparam logic [1:0] PORTS_012 = 2'h1;
    localparam logic [1:0] PORTS_013 = 2'h2;
    localparam logic [1:0] PORTS_0123 = 2'h3;

    // Values and counts
    localparam logic [4:0] PHY_ADDR_BIAS_VALUE = 5'h10;
    localparam logic [2:0] CTRL_STATUS_DEFAULT_BYTE = 3'h4;
    localparam logic [63:0] GPIO_RESET_VALUE = 64'h0;
    localparam logic [31:0] DOUT_RESET_VALUE = 32'h0;
    localparam logic [15:0] STRAP_RESET_VALUE = 16'h0;
    localparam logic [7:0] READ_UNMAPPED_VALUE = 8'h00;

    // One byte access from either side
    typedef struct packed {
        logic [11:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
        logic [7:0] wmask;
    } csg_req_s;

    // Read answer
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } csg_rsp_s;

endpackage

`default_nettype wire

// ---- csg_regs.sv ----
/*
 * Strap, identification and general purpose I/O register bank with two
 * byte-wide access sides: the network side and the process data interface.
 * Assumes one 25 MHz clock, a synchronous active-high reset during which the
 * strap pins are stable, and accesses that are synchronous to the clock.
 */
// Function
// - Port count field reports available logical ports
// - Bits 5:2 give each port's physical layer
// - CPU clock field selects pin 7 function
// - Transmit phase shift 0/90/180/270 degrees
// - Ref clock enable turns pin 31 into clock
// - Transparent mode: error pin gates TX drive
// - Relocation bit moves control/status byte
// - Bias bit adds 16 to PHY addresses
// - Link polarity bit sets link input sense
// - Strap word is read-only from both sides
// - Soft-core product identifier, read-only
// - Vendor identifier read-only, upper half reserved
// - Output data resets zero, network-only writes
// - Output data bit-writable, configurable width
// - General outputs read/write both sides, reset zero
// - General inputs read-only, zero after reset
`timescale 1ns/1ps
`default_nettype none

module csg_regs
    import csg_pkg::*;
#(
    parameter bit SOFT_CORE = 1'b0,
    parameter int DOUT_WIDTH = 32,
    parameter int GPO_WIDTH = 64,
    parameter int GPI_WIDTH = 64,
    parameter int PDI_BYTES = 8,
    // Arbitrary neutral identification values
    parameter logic [63:0] PRODUCT_IDENTIFIER = 64'h0000_0000_0000_0001,
    parameter logic [31:0] VENDOR_IDENTIFIER = 32'h0000_0001
) (
    // Clock, reset and enable
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clkEn,
    // Strap pins
    input wire logic [15:0] strapIn,
    // Network side access
    input wire csg_req_s netReq,
    output csg_rsp_s netRsp,
    // Process data interface access
    input wire csg_req_s pdiReq,
    output csg_rsp_s pdiRsp,
    // I/O data
    input wire logic [GPI_WIDTH-1:0] gpiIn,
    output logic [GPO_WIDTH-1:0] gpoOut,
    output logic [DOUT_WIDTH-1:0] doutOut,
    // Physical layer and pin control
    input wire logic errPinIn,
    input wire logic [3:0] linkRawIn,
    input wire logic [4:0] phyAddrBaseIn,
    output logic [3:0] portPresent,
    output logic [3:0] portIsMii,
    output logic [1:0] pin7ClockSel,
    output logic pin31RefClockOut,
    output logic [1:0] txPhaseShift,
    output logic txDriveEnable,
    output logic [2:0] ctrlStatusByte,
    output logic [4:0] mgmtPhyAddr,
    output logic [3:0] linkUp
);

    localparam int DOUT_BYTES = DOUT_WIDTH / 8;
    localparam int GPO_BYTES = GPO_WIDTH / 8;

    logic [15:0] strapQ;
    logic [DOUT_WIDTH-1:0] doutQ;
    logic [GPO_WIDTH-1:0] gpoQ;
    logic [GPI_WIDTH-1:0] gpiQ;

    // Strap capture: only while reset is held, so the word never moves later
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            strapQ <= strapIn;
        end
    end

    // Strap field decode
    wire logic [1:0] portCount = strapQ[POS_PORT_COUNT +: 2];
    wire logic [3:0] phyTypeBits = strapQ[POS_PORT_PHY_TYPE +: 4];
    wire logic transparentMii = strapQ[POS_TRANSPARENT_MII];
    wire logic ctrlStatusMove = strapQ[POS_CTRL_STATUS_MOVE];
    wire logic phyAddrBias = strapQ[POS_PHY_ADDR_BIAS];
    wire logic linkPolaritySelect = strapQ[POS_LINK_POLARITY_SELECT];

    wire logic [3:0] presentD = {portCount[1], portCount[0], 2'b11};
    // The third port bit serves port 2 or port 3, whichever exists alone
    wire logic port3SharesBit = (portCount == PORTS_013);
    wire logic [3:0] miiD = {
        port3SharesBit ? phyTypeBits[2] : phyTypeBits[3],
        phyTypeBits[2],
        phyTypeBits[1:0]
    } & presentD;
    wire logic [2:0] highestByte = 3'(PDI_BYTES - 1);
    wire logic [2:0] ctrlByteD = ctrlStatusMove ? highestByte : CTRL_STATUS_DEFAULT_BYTE;
    wire logic [4:0] biasD = phyAddrBias ? PHY_ADDR_BIAS_VALUE : 5'h00;
    wire logic [4:0] mgmtAddrD = 5'(phyAddrBaseIn + biasD);
    wire logic [3:0] linkD = linkPolaritySelect ? linkRawIn : ~linkRawIn;
    wire logic txDriveD = transparentMii ? errPinIn : 1'b1;

    // Pin and physical layer control outputs
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            portPresent <= 4'h0;
            portIsMii <= 4'h0;
            pin7ClockSel <= 2'h0;
            pin31RefClockOut <= 1'b0;
            txPhaseShift <= 2'h0;
            txDriveEnable <= 1'b0;
            ctrlStatusByte <= CTRL_STATUS_DEFAULT_BYTE;
            mgmtPhyAddr <= 5'h00;
            linkUp <= 4'h0;
        end else if (clkEn) begin
            portPresent <= presentD;
            portIsMii <= miiD;
            pin7ClockSel <= strapQ[POS_CPU_CLOCK_SEL +: 2];
            pin31RefClockOut <= strapQ[POS_REF_CLOCK_OUT_ENABLE];
            txPhaseShift <= strapQ[POS_TX_PHASE_SHIFT +: 2];
            txDriveEnable <= txDriveD;
            ctrlStatusByte <= ctrlByteD;
            mgmtPhyAddr <= mgmtAddrD;
            linkUp <= linkD;
        end
    end

    // Read image, padded to whole words; bytes beyond a width read zero
    wire logic [63:0] productImg = PRODUCT_IDENTIFIER;
    wire logic [63:0] vendorImg = {32'h0, VENDOR_IDENTIFIER};
    wire logic [63:0] strapImg = {48'h0, strapQ};
    wire logic [63:0] doutImg = 64'(doutQ);
    wire logic [63:0] gpoImg = 64'(gpoQ);
    wire logic [63:0] gpiImg = 64'(gpiQ);

    function automatic logic [7:0] readByte(input logic [11:0] a);
        logic [63:0] word;
        logic hit;
        word = 64'h0;
        hit = 1'b1;
        if (a[11:4] == OFS_PRODUCT_IDENTIFIER[11:4]) begin
            if (SOFT_CORE) begin
                word = a[3] ? vendorImg : productImg;
            end else if (a[3:1] == 3'h0) begin
                word = strapImg;
            end else begin
                hit = 1'b0;
            end
        end else if (a[11:3] == OFS_DIGITAL_OUTPUT_DATA[11:3]) begin
            word = doutImg;
        end else if (a[11:3] == OFS_GENERAL_PURPOSE_OUTPUTS[11:3]) begin
            word = gpoImg;
        end else if (a[11:3] == OFS_GENERAL_PURPOSE_INPUTS[11:3]) begin
            word = gpiImg;
        end else begin
            hit = 1'b0;
        end
        readByte = hit ? 8'(word >> {a[2:0], 3'b000}) : READ_UNMAPPED_VALUE;
    endfunction

    wire logic [7:0] netRdByte = readByte(netReq.addr);
    wire logic [7:0] pdiRdByte = readByte(pdiReq.addr);

    // Read answers, one cycle after the request
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            netRsp <= '0;
            pdiRsp <= '0;
        end else if (clkEn) begin
            netRsp.valid <= netReq.rd;
            netRsp.data <= netReq.rd ? netRdByte : 8'h00;
            pdiRsp.valid <= pdiReq.rd;
            pdiRsp.data <= pdiReq.rd ? pdiRdByte : 8'h00;
        end
    end

    // Digital output data: writes only from the network side, per bit
    genvar k;
    generate
        for (k = 0; k < DOUT_BYTES; k++) begin : g_dout
            wire logic hitNet = netReq.wr && (netReq.addr == 12'(OFS_DIGITAL_OUTPUT_DATA + k));
            wire logic [7:0] nextByte =
                (doutQ[8*k +: 8] & ~netReq.wmask) | (netReq.wdata & netReq.wmask);
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    doutQ[8*k +: 8] <= DOUT_RESET_VALUE[8*k +: 8];
                end else if (clkEn && hitNet) begin
                    doutQ[8*k +: 8] <= nextByte;
                end
            end
        end
        // General purpose outputs: both sides; network wins a same-byte clash
        for (k = 0; k < GPO_BYTES; k++) begin : g_gpo
            wire logic hitNet = netReq.wr && (netReq.addr == 12'(OFS_GENERAL_PURPOSE_OUTPUTS + k));
            wire logic hitPdi = pdiReq.wr && (pdiReq.addr == 12'(OFS_GENERAL_PURPOSE_OUTPUTS + k));
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    gpoQ[8*k +: 8] <= GPIO_RESET_VALUE[8*k +: 8];
                end else if (clkEn && hitNet) begin
                    gpoQ[8*k +: 8] <= netReq.wdata;
                end else if (clkEn && hitPdi) begin
                    gpoQ[8*k +: 8] <= pdiReq.wdata;
                end
            end
        end
    endgenerate

    // Inputs sampled every enabled cycle; writes to them are ignored
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            gpiQ <= GPI_WIDTH'(GPIO_RESET_VALUE);
        end else if (clkEn) begin
            gpiQ <= gpiIn;
        end
    end

    assign gpoOut = gpoQ;
    assign doutOut = doutQ;

endmodule

`default_nettype wire

// ---- csg_regs_chk.sv ----
/* Checker for the strap and GPIO register bank.
   Sees only the bank's ports; bound to every csg_regs instance. */
`timescale 1ns/1ps
`default_nettype none
module csg_regs_chk
    import csg_pkg::*;
#(
    parameter bit SOFT_CORE = 1'b0,
    parameter int GPO_WIDTH = 64,
    parameter int DOUT_WIDTH = 32
) (
    // Clock and control
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic [15:0] strapIn,
    // Access sides
    input wire csg_req_s netReq,
    input wire csg_rsp_s netRsp,
    input wire csg_req_s pdiReq,
    input wire csg_rsp_s pdiRsp,
    // Outputs watched
    input wire logic [GPO_WIDTH-1:0] gpoOut,
    input wire logic [DOUT_WIDTH-1:0] doutOut,
    input wire logic errPinIn,
    input wire logic [3:0] linkRawIn,
    input wire logic [4:0] phyAddrBaseIn,
    input wire logic [1:0] pin7ClockSel,
    input wire logic txDriveEnable,
    input wire logic [4:0] mgmtPhyAddr,
    input wire logic [3:0] linkUp
);
    logic [15:0] strapQ;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // Own copy of the straps, so no internal state is peeked at
    always_ff @(posedge sys_clk) if (srst) strapQ <= strapIn;
    // Soft-core builds map the identifier over the strap word, so only hard builds apply
    strap_read_a: assert property (!SOFT_CORE && clkEn && pdiReq.rd && pdiReq.addr == 12'hE00 |=>
        pdiRsp.valid && pdiRsp.data == strapQ[7:0]) else $error("strap byte read wrong");
    quiet_rsp_a: assert property (clkEn && !netReq.rd |=> !netRsp.valid)
        else $error("answer without read");
    dout_guard_a: assert property (pdiReq.wr && !(clkEn && netReq.wr) &&
        pdiReq.addr[11:2] == 10'h3C0 |=> $stable(doutOut)) else $error("pdi wrote dout");
    reset_zero_a: assert property (disable iff (1'b0) srst |=> gpoOut == '0 && doutOut == '0)
        else $error("outputs not cleared");
    tx_drive_a: assert property (clkEn |=>
        txDriveEnable == (strapQ[11] ? $past(errPinIn) : 1'b1)) else $error("tx drive wrong");
    phy_bias_a: assert property (clkEn |=> mgmtPhyAddr ==
        5'($past(phyAddrBaseIn) + (strapQ[13] ? 5'h10 : 5'h00))) else $error("phy addr wrong");
    link_sense_a: assert property (clkEn |=>
        linkUp == (strapQ[14] ? $past(linkRawIn) : ~$past(linkRawIn))) else $error("link wrong");
    pin7_sel_a: assert property (clkEn |=> pin7ClockSel == strapQ[7:6])
        else $error("pin 7 select wrong");
    cover property (clkEn && netReq.wr && netReq.addr == 12'hF00);
    cover property (pdiRsp.valid);
    cover property ($fell(txDriveEnable));
endmodule
bind csg_regs csg_regs_chk #(.SOFT_CORE(SOFT_CORE), .GPO_WIDTH(GPO_WIDTH),
    .DOUT_WIDTH(DOUT_WIDTH)) chk (.sys_clk, .srst, .clkEn, .strapIn, .netReq, .netRsp, .pdiReq,
    .pdiRsp, .gpoOut, .doutOut, .errPinIn, .linkRawIn, .phyAddrBaseIn, .pin7ClockSel,
    .txDriveEnable, .mgmtPhyAddr, .linkUp);
`default_nettype wire

// ---- csg_host_model.sv ----
/* Model of the network master and the local host, one byte access at a time.
   Assumes the bank takes a request one edge after it is driven. */
`timescale 1ns/1ps
`default_nettype none
module csg_host_model
    import csg_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Requests and answers
    output var csg_req_s netReq,
    output var csg_req_s pdiReq,
    input wire csg_rsp_s netRsp,
    input wire csg_rsp_s pdiRsp
);
    initial begin
        netReq = '0;
        pdiReq = '0;
    end
    task automatic acc(input logic side, input logic wr, input logic [11:0] a,
            input logic [7:0] d, input logic [7:0] m, output logic [7:0] q);
        csg_req_s r;
        r = '{addr: a, rd: !wr, wr: wr, wdata: d, wmask: m};
        @(posedge sys_clk);
        if (side) pdiReq <= r; else netReq <= r;
        @(posedge sys_clk);
        // Idle bus shows inverted data, never the stale value
        r = '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: ~d, wmask: ~m};
        if (side) pdiReq <= r; else netReq <= r;
        #1;
        q = side ? pdiRsp.data : netRsp.data;
    endtask
endmodule
`default_nettype wire

// ---- config_strap_and_gpio_regs_test.sv ----
/* Self-checking bench of the strap and GPIO register bank.
   Uses the host model for accesses and the bound checker for timing. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module config_strap_and_gpio_regs_test
    import csg_pkg::*;
;
    logic sys_clk = 0, srst = 1, errPinIn = 0, pin31RefClockOut, txDriveEnable;
    logic [15:0] strapIn = '0, s;
    logic [63:0] gpiIn = '0, gpoOut, gpoE;
    logic [31:0] doutOut, doutE, rnd = 32'hD337;
    logic [3:0] linkRawIn = '0, portPresent, portIsMii, linkUp;
    logic [4:0] phyAddrBaseIn = '0, mgmtPhyAddr;
    logic [1:0] pin7ClockSel, txPhaseShift, op;
    logic [2:0] ctrlStatusByte, b;
    logic [7:0] q, d, m, qs;
    csg_req_s netReq, pdiReq;
    csg_rsp_s netRsp, pdiRsp, netRspSoft, pdiRspSoft;
    int n_mismatch = 0, n_tests = 0, cyc = 0;
    // Arbitrary identification values for the soft-core build
    localparam logic [63:0] PROD_ID = 64'h5A5A_0F0F_3C3C_9696;
    localparam logic [31:0] VEND_ID = 32'h0000_2B2B;
    function automatic logic [31:0] nx(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [3:0] pres(logic [1:0] c);
        return {c[1], c[0], 2'h3};
    endfunction
    function automatic logic [7:0] idByte(logic [3:0] i);
        logic [127:0] img;
        img = {32'h0, VEND_ID, PROD_ID};
        return img[8*i +: 8];
    endfunction
    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    csg_regs uut (.sys_clk, .srst, .clkEn(1'b1), .strapIn, .netReq, .netRsp, .pdiReq, .pdiRsp,
        .gpiIn, .gpoOut, .doutOut, .errPinIn, .linkRawIn, .phyAddrBaseIn, .portPresent,
        .portIsMii, .pin7ClockSel, .pin31RefClockOut, .txPhaseShift, .txDriveEnable,
        .ctrlStatusByte, .mgmtPhyAddr, .linkUp);
    // Soft-core build on the same access lines; only its read answers are compared
    csg_regs #(.SOFT_CORE(1'b1), .PRODUCT_IDENTIFIER(PROD_ID), .VENDOR_IDENTIFIER(VEND_ID)) uutSoft (.sys_clk,
        .srst, .clkEn(1'b1), .strapIn, .netReq, .netRsp(netRspSoft), .pdiReq,
        .pdiRsp(pdiRspSoft), .gpiIn, .gpoOut(), .doutOut(), .errPinIn, .linkRawIn,
        .phyAddrBaseIn, .portPresent(), .portIsMii(), .pin7ClockSel(), .pin31RefClockOut(),
        .txPhaseShift(), .txDriveEnable(), .ctrlStatusByte(), .mgmtPhyAddr(), .linkUp());
    csg_host_model host (.sys_clk, .netReq, .pdiReq, .netRsp, .pdiRsp);
    always #20 sys_clk = ~sys_clk;
    // Pin-side inputs wander every cycle; the checker judges them
    always @(posedge sys_clk) begin
        rnd <= nx(rnd);
        errPinIn <= rnd[3];
        linkRawIn <= rnd[7:4];
        phyAddrBaseIn <= rnd[12:8];
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        s = '0;
        for (int k = 0; k < 4; k++) begin
            // Odd passes invert the word, so all four port count codes occur
            s = k[0] ? ~s : {rnd[15:2], k[1], 1'b1};
            strapIn <= s;
            srst <= 1'b1;
            repeat (6) @(posedge sys_clk);
            srst <= 1'b0;
            repeat (3) @(posedge sys_clk);
            `CHK("ports", pres(s[1:0]), portPresent)
            `CHK("mii", {s[1:0] == 2'h2 ? s[4] : s[5], s[4:2]} & pres(s[1:0]), portIsMii)
            `CHK("phase", s[9:8], txPhaseShift)
            `CHK("refclk", s[10], pin31RefClockOut)
            `CHK("ctrl byte", s[12] ? 3'h7 : 3'h4, ctrlStatusByte)
            `CHK("dout reset", 32'h0, doutOut)
            // Writes to the identification range must leave every byte alone
            for (int i = 0; i < 16; i++) begin
                host.acc(i[0], 1'b1, 12'hE00 + 12'(i), ~s[8*i[0] +: 8], 8'hFF, q);
                host.acc(!i[0], 1'b0, 12'hE00 + 12'(i), 8'h00, 8'h00, q);
                qs = i[0] ? netRspSoft.data : pdiRspSoft.data;
                `CHK("strap", i < 2 ? s[8*i[0] +: 8] : 8'h00, q)
                `CHK("ident", idByte(i[3:0]), qs)
            end
            host.acc(1'b0, 1'b0, 12'hF20, 8'h00, 8'h00, q);
            `CHK("unmapped", 8'h00, q)
            doutE = '0;
            gpoE = '0;
            for (int j = 0; j < 16; j++) begin
                {m, d, b, op} = rnd[20:0];
                gpiIn <= {rnd, ~rnd};
                if (op[1]) begin
                    host.acc(op[0], 1'b1, 12'hF10 + b, d, m, q);
                    gpoE[8*b +: 8] = d;
                end else begin
                    host.acc(op[0], 1'b1, 12'hF00 + b[1:0], d, m, q);
                    if (!op[0]) doutE[8*b[1:0] +: 8] = doutE[8*b[1:0] +: 8] & ~m | d & m;
                end
                `CHK("dout", doutE, doutOut)
                `CHK("gpo", gpoE, gpoOut)
                host.acc(b[0], 1'b0, 12'hF18 + b, 8'h00, 8'h00, q);
                `CHK("gpi", gpiIn[8*b +: 8], q)
                host.acc(b[1], 1'b0, 12'hF10 + b, 8'h00, 8'h00, q);
                `CHK("gpo read", gpoE[8*b +: 8], q)
                host.acc(1'b1, 1'b0, 12'hF00 + b[1:0], 8'h00, 8'h00, q);
                `CHK("dout read", doutE[8*b[1:0] +: 8], q)
            end
        end
        end_of_test();
    end
endmodule
`default_nettype wire
